// ===== rtl/aidr_device.sv
// Analog input module diagnostic record, ticker and diagnostic interrupts
// How it works
// - 32-bit microsecond ticker, zero at reset
// - Ticker wraps to zero and keeps counting
// - Hardware event snapshot keeps ticker low 16 bits
// - Incoming diagnostic interrupts only while enable set, going ones always
// - Incoming on cause, going when cause clears
// - Channel events between incoming and going dropped
// - Fault indicator lit while any source active
// - Set 01h full record, 00h four bytes
// - Index 2F01h full, 2F00h four bytes
// - Index 5005h subindexes map record bytes
// - First byte holds module fault summary bits
// - Module info byte is class 0101b, bit4
// - Fourth byte: buffer, communication, lost interrupt
// - Channel kind code 71h analog input
// - Eight diagnostic bits per channel
// - Channel count byte reports four
// - Group error bit n per channel n
// - Channel byte: config, lost, underflow, overflow
// - Timestamp captured at each diagnostic event
`timescale 1ns/1ps
`include "aidr_cfg.svh"
module aidr_device
    import aidr_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    aidr_if.dev             link,
    input  wire logic [3:0] chan_cfg_err,
    input  wire logic [3:0] chan_irq_lost,
    input  wire logic [3:0] chan_underflow,
    input  wire logic [3:0] chan_overflow,
    input  wire logic       param_err,
    input  wire logic       aux_supply_missing,
    input  wire logic       diag_buf_overflow,
    input  wire logic       comm_err,
    input  wire logic       hw_irq_event,
    output logic            module_fault_indicator,
    output logic [15:0]     ticker_low_snapshot
);
    typedef struct packed {
        logic [4:0]       presc;
        logic [31:0]      ticker;
        logic [15:0]      snap_lo;
        logic [4:0]       active;
        aidr_byte_t [3:0] lat_ch;
        logic [3:0]       lat_mod;
        logic [31:0]      stamp;
        aidr_irq_st_t     fsm;
        logic             irq_valid;
        logic             irq_going;
        logic [2:0]       irq_src;
        logic             rd_valid;
        aidr_byte_t       rd_data;
        logic             rd_err;
    } aidr_dev_st_t;

    aidr_dev_st_t     st_q;
    aidr_dev_st_t     st_d;
    aidr_byte_t [3:0] chan_byte;
    logic [4:0]       cause;
    logic [4:0]       change;

    // Lowest numbered source that needs an interrupt
    function automatic logic [2:0] aidr_first(input logic [4:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 4; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : aidr_first

    // Record byte at a given offset
    function automatic aidr_byte_t aidr_rec_byte(input logic [4:0] b, input aidr_dev_st_t s);
        aidr_byte_t r;
        r = 8'h00;
        if (b == `AIDR_B_ERRA)
        begin
            r = {s.lat_mod[3], 2'b00, s.lat_mod[2], |s.active[3:0],
                 s.lat_mod[2], s.lat_mod[1] | s.lat_mod[0], |s.active};
        end
        else if (b == `AIDR_B_MODULE_CLASS_INFO)
        begin
            r = `AIDR_MODULE_CLASS_INFO_VAL;
        end
        else if (b == `AIDR_B_ERRD)
        begin
            r = {1'b0, s.lat_ch[0][5] | s.lat_ch[1][5] | s.lat_ch[2][5] | s.lat_ch[3][5],
                 1'b0, s.lat_mod[0], s.lat_mod[1], 3'b000};
        end
        else if (b == `AIDR_B_CHANNEL_KIND_CODE)
        begin
            r = `AIDR_CHANNEL_KIND_CODE_VAL;
        end
        else if (b == `AIDR_B_DIAG_BITS_PER_CHANNEL)
        begin
            r = `AIDR_DIAG_BITS_PER_CHANNEL_VAL;
        end
        else if (b == `AIDR_B_CHANNEL_COUNT)
        begin
            r = `AIDR_CHANNEL_COUNT_VAL;
        end
        else if (b == `AIDR_B_GROUP_ERROR_FLAGS)
        begin
            r = {4'h0, s.active[3:0]};
        end
        else if (b >= `AIDR_B_CH0 && b < `AIDR_B_CH0 + 5'h04)
        begin
            r = s.lat_ch[2'(b - `AIDR_B_CH0)];
        end
        else if (b >= `AIDR_B_STAMP && b < `AIDR_REC_LEN)
        begin
            r = s.stamp[8 * 32'(2'(b - `AIDR_B_STAMP)) +: 8];
        end
        return r;
    endfunction : aidr_rec_byte

    generate
        for (genvar g = 0; g < `AIDR_NUM_CHAN; g++)
        begin : g_chan
            assign chan_byte[g] = {chan_overflow[g], chan_underflow[g], chan_irq_lost[g],
                                   4'h0, chan_cfg_err[g]};
            assign cause[g]     = |chan_byte[g];
        end
    endgenerate
    assign cause[4] = param_err | aux_supply_missing | diag_buf_overflow | comm_err;
    // New incoming only while enabled, going always follows
    assign change = ((cause & ~st_q.active) & {5{link.diag_en}}) | (~cause & st_q.active);

    always_comb
    begin
        st_d          = st_q;
        st_d.rd_valid = 1'b0;
        if (st_q.presc == `AIDR_PRESC_LAST)
        begin
            st_d.presc  = 5'h00;
            st_d.ticker = st_q.ticker + 32'h0000_0001;
        end
        else
        begin
            st_d.presc = st_q.presc + 5'h01;
        end
        // Low half sampled at hardware event
        if (hw_irq_event)
        begin
            st_d.snap_lo = st_q.ticker[15:0];
        end
        case (st_q.fsm)
            AIDR_IRQ_IDLE:
            begin
                if (|change)
                begin
                    st_d.irq_src   = aidr_first(change);
                    st_d.irq_going = st_q.active[aidr_first(change)];
                    st_d.irq_valid = 1'b1;
                    st_d.fsm       = AIDR_IRQ_WAIT;
                    st_d.stamp     = st_q.ticker;
                    // Incoming latches cause, going clears it
                    st_d.active[aidr_first(change)] = ~st_q.active[aidr_first(change)];
                    if (aidr_first(change) == `AIDR_MOD_SRC)
                    begin
                        st_d.lat_mod = st_q.active[4] ? 4'h0 :
                            {param_err, aux_supply_missing, diag_buf_overflow, comm_err};
                    end
                    else
                    begin
                        st_d.lat_ch[2'(aidr_first(change))] =
                            st_q.active[aidr_first(change)] ? 8'h00 :
                            chan_byte[2'(aidr_first(change))];
                    end
                end
            end
            AIDR_IRQ_WAIT:
            begin
                if (link.irq_ack)
                begin
                    st_d.irq_valid = 1'b0;
                    st_d.fsm       = AIDR_IRQ_IDLE;
                end
            end
            default:
            begin
                st_d.fsm       = AIDR_IRQ_IDLE;
                st_d.irq_valid = 1'b0;
            end
        endcase
        // Short set limited to four bytes
        if (link.rd_req)
        begin
            st_d.rd_valid = 1'b1;
            st_d.rd_err   = link.rd_byte >= (link.rd_full ? `AIDR_REC_LEN : `AIDR_SHORT_LEN);
            st_d.rd_data  = st_d.rd_err ? 8'h00 : aidr_rec_byte(link.rd_byte, st_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Ticker and record cleared at reset
            st_q     <= '0;
            st_q.fsm <= AIDR_IRQ_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign link.irq_valid = st_q.irq_valid;
    assign link.irq_going = st_q.irq_going;
    assign link.irq_src   = st_q.irq_src;
    assign link.rd_valid  = st_q.rd_valid;
    assign link.rd_data   = st_q.rd_data;
    assign link.rd_err    = st_q.rd_err;
    // Lit from first incoming to last going
    assign module_fault_indicator = |st_q.active;
    assign ticker_low_snapshot    = st_q.snap_lo;
endmodule : aidr_device

// ===== rtl/aidr_cfg.svh
// Constants of the analog input diagnostic record
`ifndef AIDR_CFG_SVH
`define AIDR_CFG_SVH
`define AIDR_CLK_PERIOD_NS  40
`define AIDR_TICK_PERIOD_NS 1000
`define AIDR_PRESC_CYCLES   (`AIDR_TICK_PERIOD_NS / `AIDR_CLK_PERIOD_NS)
`define AIDR_PRESC_LAST     5'((`AIDR_PRESC_CYCLES) - 1)
`define AIDR_NUM_CHAN       4
`define AIDR_MOD_SRC        3'h4
`define AIDR_MODULE_CLASS_INFO_VAL     8'h15
`define AIDR_CHANNEL_KIND_CODE_VAL      8'h71
`define AIDR_DIAG_BITS_PER_CHANNEL_VAL     8'h08
`define AIDR_CHANNEL_COUNT_VAL      8'h04
`define AIDR_REC_LEN        5'h14
`define AIDR_SHORT_LEN      5'h04
`define AIDR_B_ERRA         5'h00
`define AIDR_B_MODULE_CLASS_INFO       5'h01
`define AIDR_B_ERRD         5'h03
`define AIDR_B_CHANNEL_KIND_CODE        5'h04
`define AIDR_B_DIAG_BITS_PER_CHANNEL       5'h05
`define AIDR_B_CHANNEL_COUNT        5'h06
`define AIDR_B_GROUP_ERROR_FLAGS        5'h07
`define AIDR_B_CH0          5'h08
`define AIDR_B_STAMP        5'h10
`define AIDR_PATH_DS        2'h0
`define AIDR_PATH_IX        2'h1
`define AIDR_PATH_SX        2'h2
`define AIDR_DS_FULL        16'h0001
`define AIDR_DS_SHORT       16'h0000
`define AIDR_IX_FULL        16'h2f01
`define AIDR_IX_SHORT       16'h2f00
`define AIDR_SX_INDEX       16'h5005
`define AIDR_SX_FIRST       8'h02
`define AIDR_REG_CTRL       32'h0000_0000
`define AIDR_REG_ACCESS     32'h0000_0004
`define AIDR_REG_DATA       32'h0000_0008
`define AIDR_REG_EVENT      32'h0000_000c
`define AIDR_EVT_PEND_BIT   4
`endif

// ===== rtl/aidr_pkg.sv
// Types shared by both ends of the diagnostic record link
package aidr_pkg;
    typedef enum logic [1:0] {
        AIDR_IRQ_IDLE = 2'b01,
        AIDR_IRQ_WAIT = 2'b10
    } aidr_irq_st_t;
    typedef enum logic [1:0] {
        AIDR_CTL_IDLE = 2'b01,
        AIDR_CTL_BUSY = 2'b10
    } aidr_ctl_st_t;
    typedef logic [7:0] aidr_byte_t;
endpackage : aidr_pkg

// ===== rtl/aidr_if.sv
// Backplane link between diagnostic record device and controller
`timescale 1ns/1ps
interface aidr_if;
    logic       diag_en;
    logic       rd_req;
    logic       rd_full;
    logic [4:0] rd_byte;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       rd_err;
    logic       irq_valid;
    logic       irq_going;
    logic [2:0] irq_src;
    logic       irq_ack;
    modport dev (input diag_en, input rd_req, input rd_full, input rd_byte,
                 output rd_valid, output rd_data, output rd_err,
                 output irq_valid, output irq_going, output irq_src, input irq_ack);
    modport ctl (output diag_en, output rd_req, output rd_full, output rd_byte,
                 input rd_valid, input rd_data, input rd_err,
                 input irq_valid, input irq_going, input irq_src, output irq_ack);
endinterface : aidr_if

// ===== rtl/aidr_ctrl.sv
// Controller end: AHB-Lite registers driving the diagnostic record link
`timescale 1ns/1ps
`include "aidr_cfg.svh"
module aidr_ctrl
    import aidr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    aidr_if.ctl              link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);
    typedef struct packed {
        aidr_ctl_st_t fsm;
        logic         en;
        logic [31:0]  access;
        aidr_byte_t   data;
        logic         done;
        logic         err;
        logic [2:0]   evt_src;
        logic         evt_going;
        logic         evt_pend;
        logic         dp_wr;
        logic [31:0]  dp_addr;
        logic [31:0]  rdata;
        logic         rd_req;
        logic         rd_full;
        logic [4:0]   rd_byte;
    } aidr_ctl_q_t;

    aidr_ctl_q_t st_q;
    aidr_ctl_q_t st_d;
    logic [6:0]  map;

    // Path, selector and byte to {ok, full, byte}
    function automatic logic [6:0] aidr_map(input logic [31:0] a);
        logic [6:0] m;
        m = 7'h00;
        if (a[1:0] == `AIDR_PATH_DS && a[23:8] == `AIDR_DS_FULL)
        begin
            m = {2'b11, a[28:24]};
        end
        else if (a[1:0] == `AIDR_PATH_DS && a[23:8] == `AIDR_DS_SHORT)
        begin
            m = {2'b10, a[28:24]};
        end
        else if (a[1:0] == `AIDR_PATH_IX && a[23:8] == `AIDR_IX_FULL)
        begin
            m = {2'b11, a[28:24]};
        end
        else if (a[1:0] == `AIDR_PATH_IX && a[23:8] == `AIDR_IX_SHORT)
        begin
            m = {2'b10, a[28:24]};
        end
        else if (a[1:0] == `AIDR_PATH_SX && a[23:8] == `AIDR_SX_INDEX
                 && a[31:24] >= `AIDR_SX_FIRST)
        begin
            m = {2'b11, 5'(a[31:24] - `AIDR_SX_FIRST)};
        end
        return m;
    endfunction : aidr_map

    assign map = aidr_map(hwdata);

    always_comb
    begin
        st_d        = st_q;
        st_d.rd_req = 1'b0;
        st_d.dp_wr  = 1'b0;
        // Address phase: capture and prepare read data
        if (hsel && htrans[1] && hready)
        begin
            st_d.dp_wr   = hwrite;
            st_d.dp_addr = haddr;
            st_d.rdata   = 32'h0000_0000;
            if (haddr == `AIDR_REG_CTRL)
            begin
                st_d.rdata = {31'h0, st_q.en};
            end
            else if (haddr == `AIDR_REG_ACCESS)
            begin
                st_d.rdata = st_q.access;
            end
            else if (haddr == `AIDR_REG_DATA)
            begin
                st_d.rdata = {22'h0, st_q.err, st_q.done, st_q.data};
            end
            else if (haddr == `AIDR_REG_EVENT)
            begin
                st_d.rdata = {27'h0, st_q.evt_pend, st_q.evt_going, st_q.evt_src};
            end
        end
        // Data phase write
        if (st_q.dp_wr)
        begin
            if (st_q.dp_addr == `AIDR_REG_CTRL)
            begin
                st_d.en = hwdata[0];
            end
            else if (st_q.dp_addr == `AIDR_REG_ACCESS && st_q.fsm == AIDR_CTL_IDLE)
            begin
                st_d.access = hwdata;
                st_d.done   = ~map[6];
                st_d.err    = ~map[6];
                st_d.data   = 8'h00;
                if (map[6])
                begin
                    st_d.rd_req  = 1'b1;
                    st_d.rd_full = map[5];
                    st_d.rd_byte = map[4:0];
                    st_d.fsm     = AIDR_CTL_BUSY;
                end
            end
            else if (st_q.dp_addr == `AIDR_REG_EVENT && hwdata[`AIDR_EVT_PEND_BIT])
            begin
                st_d.evt_pend = 1'b0;
            end
        end
        case (st_q.fsm)
            AIDR_CTL_IDLE:
            begin
            end
            AIDR_CTL_BUSY:
            begin
                if (link.rd_valid)
                begin
                    st_d.data = link.rd_data;
                    st_d.err  = link.rd_err;
                    st_d.done = 1'b1;
                    st_d.fsm  = AIDR_CTL_IDLE;
                end
            end
            default:
            begin
                st_d.fsm = AIDR_CTL_IDLE;
            end
        endcase
        // Event capture, set wins over clear
        if (link.irq_valid)
        begin
            st_d.evt_src   = link.irq_src;
            st_d.evt_going = link.irq_going;
            st_d.evt_pend  = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q     <= '0;
            st_q.fsm <= AIDR_CTL_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign link.diag_en = st_q.en;
    assign link.rd_req  = st_q.rd_req;
    assign link.rd_full = st_q.rd_full;
    assign link.rd_byte = st_q.rd_byte;
    assign link.irq_ack = link.irq_valid;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = st_q.rdata;
endmodule : aidr_ctrl

// ===== verif/aidr_link_sva.sv
// Assertions on the link between the diagnostic record ends
`timescale 1ns/1ps
module aidr_link_sva
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       diag_en,
    input wire logic       rd_req,
    input wire logic       rd_full,
    input wire logic [4:0] rd_byte,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic       rd_err,
    input wire logic       irq_valid,
    input wire logic       irq_going,
    input wire logic [2:0] irq_src,
    input wire logic       irq_ack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_read_answer: assert property (
        rd_req |=> rd_valid ##1 !rd_valid) else $error("link read answer wrong");
    a_length_limit: assert property (
        rd_valid |-> rd_err == (rd_byte >= (rd_full ? 5'h14 : 5'h04)))
        else $error("record length error flag wrong");
    a_class_byte: assert property (
        rd_valid && rd_byte == 5'h01 |-> rd_data == 8'h15) else $error("class byte");
    a_kind_byte: assert property (
        rd_valid && rd_full && rd_byte == 5'h04 |-> rd_data == 8'h71) else $error("kind byte");
    a_bits_count: assert property (
        rd_valid && rd_full && rd_byte == 5'h05 |-> rd_data == 8'h08) else $error("bits byte");
    a_chan_count: assert property (
        rd_valid && rd_full && rd_byte == 5'h06 |-> rd_data == 8'h04) else $error("count byte");
    a_fault_rsvd: assert property (
        rd_valid && rd_byte == 5'h00 |-> rd_data[6:5] == 2'h0) else $error("byte 0 reserved");
    a_intern_rsvd: assert property (
        rd_valid && rd_byte == 5'h03 |-> (rd_data & 8'ha7) == 8'h00) else $error("byte 3 reserved");
    a_group_rsvd: assert property (
        rd_valid && rd_full && rd_byte == 5'h07 |-> rd_data[7:4] == 4'h0)
        else $error("group byte reserved");
    a_chan_rsvd: assert property (
        rd_valid && rd_full && rd_byte inside {[5'h08:5'h0b]} |-> rd_data[4:1] == 4'h0)
        else $error("channel byte reserved");
    a_irq_pulse: assert property (
        irq_valid |-> irq_src <= 3'h4 ##1 !irq_valid) else $error("interrupt pulse wrong");
    a_irq_enabled: assert property (
        irq_valid && !irq_going |-> $past(diag_en)) else $error("incoming while disabled");
    a_ack_same: assert property (
        irq_ack == irq_valid) else $error("ack differs from valid");
endmodule : aidr_link_sva

// ===== verif/testbench.sv
// Self-checking bench for both ends of the diagnostic record link
`timescale 1ns/1ps
module testbench;
    import aidr_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  cfg_err = 4'h0;
    logic [3:0]  lost = 4'h0;
    logic [3:0]  under = 4'h0;
    logic [3:0]  over = 4'h0;
    logic [3:0]  mod_err = 4'h0;
    logic        hw_evt = 1'b0;
    logic        led;
    logic [15:0] snap;
    logic [15:0] snap0;
    logic [31:0] rdv;
    int          fails = 0;
    int          tests_run = 0;
    logic [7:0]  rest [0:7] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h04, 8'h00};
    logic [15:0] sels [0:2] = '{16'h0001, 16'h2f01, 16'h5005};

    always #20 hclk = ~hclk;

    aidr_if u_aidr_if ();
    aidr_ctrl u_aidr_ctrl (.hclk(hclk), .hresetn(hresetn), .link(u_aidr_if), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    aidr_device u_aidr_device (.hclk(hclk), .hresetn(hresetn), .link(u_aidr_if),
        .chan_cfg_err(cfg_err), .chan_irq_lost(lost), .chan_underflow(under),
        .chan_overflow(over), .param_err(mod_err[0]), .aux_supply_missing(mod_err[1]),
        .diag_buf_overflow(mod_err[2]), .comm_err(mod_err[3]), .hw_irq_event(hw_evt),
        .module_fault_indicator(led), .ticker_low_snapshot(snap));
    aidr_link_sva u_aidr_link_sva (.hclk(hclk), .hresetn(hresetn),
        .diag_en(u_aidr_if.diag_en), .rd_req(u_aidr_if.rd_req), .rd_full(u_aidr_if.rd_full),
        .rd_byte(u_aidr_if.rd_byte), .rd_valid(u_aidr_if.rd_valid),
        .rd_data(u_aidr_if.rd_data), .rd_err(u_aidr_if.rd_err),
        .irq_valid(u_aidr_if.irq_valid), .irq_going(u_aidr_if.irq_going),
        .irq_src(u_aidr_if.irq_src), .irq_ack(u_aidr_if.irq_ack));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    // One single AHB-Lite transfer, read data left in rdv
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : ahb

    // Record byte fetch through the link, then compare DATA
    task automatic rec(input logic [1:0] path, input logic [15:0] sel, input logic [7:0] off,
                       input logic [31:0] exp);
        ahb(1'b1, 32'h4, {off, sel, 6'h00, path});
        do ahb(1'b0, 32'h8, 32'h0); while (rdv[8] !== 1'b1);
        check(rdv, exp);
    endtask : rec

    task automatic evt(input logic [31:0] exp);
        ahb(1'b0, 32'hc, 32'h0);
        check(rdv, exp);
        ahb(1'b1, 32'hc, 32'h10);
    endtask : evt

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #1000000;
        fails++;
        tally_and_finish();
    end

    initial
    begin
        cyc(4);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0, 32'h0);
        check(rdv, 32'h0);
        check({31'h0, hresp}, 32'h0);
        ahb(1'b1, 32'h20, 32'hffffffff);
        ahb(1'b0, 32'h20, 32'h0);
        check(rdv, 32'h0);
        for (int p = 0; p < 3; p++)
            for (int i = 0; i < 20; i++)
                rec(2'(p), sels[p], 8'(i + (p == 2 ? 2 : 0)),
                    {23'h0, 1'b1, i < 8 ? rest[i] : 8'h00});
        ahb(1'b0, 32'h4, 32'h0);
        check(rdv, 32'h15500502);
        // Second selector write while a link read is in flight is refused
        ahb(1'b1, 32'h4, 32'h01000100);
        ahb(1'b1, 32'h4, 32'h02000100);
        ahb(1'b0, 32'h4, 32'h0);
        check(rdv, 32'h01000100);
        rec(2'h0, 16'h0000, 8'h03, 32'h100);
        rec(2'h0, 16'h0000, 8'h04, 32'h300);
        rec(2'h1, 16'h2f00, 8'h01, 32'h115);
        rec(2'h1, 16'h2f00, 8'h04, 32'h300);
        rec(2'h0, 16'h0001, 8'h14, 32'h300);
        rec(2'h0, 16'h1234, 8'h00, 32'h300);
        rec(2'h3, 16'h0001, 8'h00, 32'h300);
        ahb(1'b1, 32'h0, 32'h1);
        over[1] <= 1'b1;
        cyc(4);
        check({31'h0, led}, 32'h1);
        evt(32'h11);
        rec(2'h0, 16'h0001, 8'h07, 32'h102);
        rec(2'h0, 16'h0001, 8'h09, 32'h180);
        rec(2'h0, 16'h0001, 8'h00, 32'h109);
        over[1]  <= 1'b0;
        under[1] <= 1'b1;
        cyc(4);
        rec(2'h0, 16'h0001, 8'h09, 32'h180);
        evt(32'h01);
        under[1] <= 1'b0;
        cyc(4);
        evt(32'h19);
        check({31'h0, led}, 32'h0);
        rec(2'h0, 16'h0001, 8'h09, 32'h100);
        lost[2]    <= 1'b1;
        mod_err[2] <= 1'b1;
        cyc(6);
        evt(32'h14);
        rec(2'h0, 16'h0001, 8'h03, 32'h148);
        rec(2'h0, 16'h0001, 8'h00, 32'h10b);
        rec(2'h0, 16'h0001, 8'h0a, 32'h120);
        rec(2'h0, 16'h0001, 8'h07, 32'h104);
        lost[2]    <= 1'b0;
        mod_err[2] <= 1'b0;
        cyc(6);
        evt(32'h1c);
        over[0] <= 1'b1;
        cyc(4);
        ahb(1'b1, 32'h0, 32'h0);
        over[0] <= 1'b0;
        cyc(4);
        evt(32'h18);
        mod_err[0] <= 1'b1;
        cyc(6);
        evt(32'h08);
        check({31'h0, led}, 32'h0);
        mod_err[0] <= 1'b0;
        hw_evt <= 1'b1;
        @(posedge hclk);
        hw_evt <= 1'b0;
        cyc(2);
        snap0 = snap;
        cyc(247);
        hw_evt <= 1'b1;
        @(posedge hclk);
        hw_evt <= 1'b0;
        cyc(2);
        check({16'h0, snap - snap0}, 32'h0000_000a);
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        hw_evt  <= 1'b1;
        @(posedge hclk);
        hw_evt <= 1'b0;
        ahb(1'b1, 32'h0, 32'h1);
        cyc(134);
        over[3] <= 1'b1;
        hw_evt  <= 1'b1;
        @(posedge hclk);
        hw_evt <= 1'b0;
        cyc(3);
        check({16'h0, snap}, 32'h5);
        for (int i = 0; i < 4; i++)
            rec(2'h2, 16'h5005, 8'(18 + i), {24'h1, i == 0 ? 8'h05 : 8'h00});
        over[3] <= 1'b0;
        cyc(4);
        tally_and_finish();
    end
endmodule : testbench
